// >>> rtl/pllcg_control.sv
// pllcg_control.sv: digital control of a crystal-referenced clock generator
// assumes crystal and oscillator clocks arrive as levels far slower than mclk,
// and that control inputs come from software logic on mclk
//
// Contract
// - base clock is crystal or oscillator clock halved, chosen by source select
// - in user mode the bus clock runs at half the base clock
// - in monitor mode the monitor clock select pin chooses the bus clock source
// - oscillator runs when system enable or stop-mode enable is set
// - crystal clock is buffered into the loop reference clock
// - reference divider divides the reference clock by R
// - feedback clock is the oscillator divided by two to the P, then by N
// - phase detector gives up or down pulses sized by the phase difference
// - lock detector compares feedback and divided reference frequencies
// - centre-of-range frequency is nominal step times L times two to the E
// - tracking flag is zero in acquisition; otherwise the filter tracks
// - with automatic bandwidth the lock detector switches filter modes itself
// - automatic mode: tracking flag read-only, follows frequency tolerance
// - automatic mode: in-sync flag read-only, follows frequency tolerance
// - interrupt enabled: interrupt on every in-sync flag change
// - manual mode: tracking flag is software written, cleared before power on
// - manual mode: in-sync function off and no interrupts
// - R or N programmed zero acts as one
// - L of zero disables the loop and forces the crystal clock
// - source switch waits up to three edges of each clock, output held
// - no selection while off, no power off while selected, not together
`timescale 1ns/10ps
module pllcg_control
  import pllcg_pkg::*;
#(
  parameter int R_W = 8,
  parameter int N_W = 12,
  parameter int P_W = 2,
  parameter int E_W = 2,
  parameter int L_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // clocks from outside the mclk domain
  input wire logic crystal_clock,
  input wire logic vco_clock,
  input wire logic monitor_clock_select_pin,
  // control bits from software and the system integration unit
  input wire logic system_oscillator_enable,
  input wire logic oscillator_stop_mode_enable,
  input wire logic monitor_mode,
  input wire logic pll_power_on,
  input wire logic base_clock_source_select,
  input wire logic auto_bandwidth,
  input wire logic tracking_mode_write,
  input wire logic pll_irq_enable,
  input wire logic [R_W-1:0] ref_div_r,
  input wire logic [P_W-1:0] prescale_p,
  input wire logic [N_W-1:0] fb_div_n,
  input wire logic [E_W-1:0] range_e,
  input wire logic [L_W-1:0] linear_l,
  // clock outputs
  output logic oscillator_enable,
  output logic pll_reference_clock,
  output logic divided_reference_clock,
  output logic vco_feedback_clock,
  output logic base_clock_out,
  output logic bus_clock_out,
  // loop filter steering
  output logic pd_up,
  output logic pd_down,
  output logic [L_W+2:0] vco_center_mult,
  // status
  output logic tracking_mode_flag,
  output logic in_sync_flag,
  output logic pll_active,
  output logic vco_selected,
  output logic clock_switch_busy,
  output logic pll_irq
);

  // two-flop synchronisers; the first stage feeds only the second
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic xc_prev_q;
  logic vc_prev_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      xc_prev_q <= 1'b0;
      vc_prev_q <= 1'b0;
    end else begin
      sync1_q <= {monitor_clock_select_pin, vco_clock, crystal_clock};
      sync2_q <= sync1_q;
      xc_prev_q <= sync2_q[0];
      vc_prev_q <= sync2_q[1];
    end
  end

  logic xc_rise;
  logic xc_fall;
  logic vc_rise;
  logic vc_fall;
  logic mon_pin;
  assign xc_rise = sync2_q[0] & ~xc_prev_q;
  assign xc_fall = ~sync2_q[0] & xc_prev_q;
  assign vc_rise = sync2_q[1] & ~vc_prev_q;
  assign vc_fall = ~sync2_q[1] & vc_prev_q;
  assign mon_pin = sync2_q[2];

  // zero divisors act as one
  logic [R_W-1:0] r_eff;
  logic [N_W-1:0] n_eff;
  logic [7:0] pre_last;
  assign r_eff = (ref_div_r == '0) ? R_W'(1) : ref_div_r;
  assign n_eff = (fb_div_n == '0) ? N_W'(1) : fb_div_n;
  assign pre_last = 8'((9'h1 << prescale_p) - 9'h1);

  // divider and detector state
  logic osc_en_q, osc_en_d;
  logic ref_clk_q, ref_clk_d;
  logic [R_W-1:0] rcnt_q, rcnt_d;
  logic rdv_q, rdv_d;
  logic [7:0] pcnt_q, pcnt_d;
  logic [N_W-1:0] ncnt_q, ncnt_d;
  logic vdv_q, vdv_d;
  logic up_q, up_d;
  logic dn_q, dn_d;
  logic [1:0] fb_seen_q, fb_seen_d;
  logic [3:0] good_q, good_d;
  logic acq_q, acq_d;
  logic lock_q, lock_d;
  logic irq_q, irq_d;
  logic pll_on_q, pll_on_d;
  logic pll_en;
  logic rdv_evt;
  logic vdv_evt;
  logic window_ok;

  assign pll_en = pll_on_q & (linear_l != '0);
  // R lowered below the running count wraps at once; N lowered below its count waits out a full roll
  assign rdv_evt = xc_rise & (rcnt_q >= r_eff - R_W'(1));
  assign vdv_evt = vc_rise & pll_en & (pcnt_q == pre_last) & (ncnt_q == n_eff - N_W'(1));
  // exactly one feedback edge per reference period means matched frequency
  assign window_ok = (fb_seen_q == 2'h1);

  // dividers, phase and lock detection
  always_comb begin
    osc_en_d = system_oscillator_enable | oscillator_stop_mode_enable;
    ref_clk_d = sync2_q[0];
    rcnt_d = rcnt_q;
    rdv_d = rdv_q;
    pcnt_d = pcnt_q;
    ncnt_d = ncnt_q;
    vdv_d = vdv_q;
    up_d = up_q;
    dn_d = dn_q;
    fb_seen_d = fb_seen_q;
    good_d = good_q;
    acq_d = acq_q;
    lock_d = lock_q;
    irq_d = 1'b0;
    // reference divider: high from a wrap edge to the next falling edge
    if (xc_rise) begin
      rcnt_d = rdv_evt ? '0 : rcnt_q + R_W'(1);
    end
    if (rdv_evt) begin
      rdv_d = 1'b1;
    end else if (xc_fall) begin
      rdv_d = 1'b0;
    end
    // prescaler by two to the P, then modulo N
    if (!pll_en) begin
      pcnt_d = '0;
      ncnt_d = '0;
      vdv_d = 1'b0;
    end else begin
      if (vc_rise) begin
        pcnt_d = (pcnt_q == pre_last) ? 8'h00 : pcnt_q + 8'h01;
        if (pcnt_q == pre_last) begin
          ncnt_d = vdv_evt ? '0 : ncnt_q + N_W'(1);
        end
      end
      if (vdv_evt) begin
        vdv_d = 1'b1;
      end else if (vc_fall) begin
        vdv_d = 1'b0;
      end
    end
    // phase detector: the leading edge opens a pulse, the lagging one ends it
    if (!pll_en) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end else if (rdv_evt && vdv_evt) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end else if (rdv_evt) begin
      up_d = ~dn_q;
      dn_d = 1'b0;
    end else if (vdv_evt) begin
      dn_d = ~up_q;
      up_d = 1'b0;
    end
    // frequency comparison over each divided reference period
    if (vdv_evt && fb_seen_q != 2'h3) begin
      fb_seen_d = fb_seen_q + 2'h1;
    end
    if (rdv_evt) begin
      fb_seen_d = {1'b0, vdv_evt};
      if (window_ok) begin
        good_d = (good_q == 4'hF) ? good_q : good_q + 4'h1;
      end else begin
        good_d = 4'h0;
      end
    end
    // automatic bandwidth: the detector owns both flags
    acq_d = (good_d >= `PLLCG_TRACK_WINDOWS);
    lock_d = (good_d >= `PLLCG_SYNC_WINDOWS);
    if (!pll_en || !auto_bandwidth) begin
      good_d = 4'h0;
      fb_seen_d = 2'h0;
      acq_d = 1'b0;
      lock_d = 1'b0;
    end
    // one pulse per in-sync change, only in automatic mode
    irq_d = auto_bandwidth & pll_irq_enable & (lock_d != lock_q);
  end

  // base clock selection and transition control
  pllcg_sel_state_t st_q, st_d;
  logic vco_sel_q, vco_sel_d;
  logic [1:0] ecnt_q, ecnt_d;
  logic base_q, base_d;
  logic bus_q, bus_d;
  logic want_vco;
  logic old_edge;
  logic new_edge;
  logic sel_edge;
  logic base_rise;

  // power may not drop while the oscillator clock is selected or being left
  assign want_vco = base_clock_source_select & pll_en & (pll_on_d == pll_on_q);
  assign old_edge = vco_sel_q ? vc_rise : xc_rise;
  assign new_edge = vco_sel_q ? xc_rise : vc_rise;
  assign sel_edge = vco_sel_q ? vc_rise : xc_rise;
  assign base_rise = base_d & ~base_q;

  always_comb begin
    pll_on_d = pll_power_on | vco_sel_q | (st_q != PLLCG_SEL_RUN);
    st_d = st_q;
    vco_sel_d = vco_sel_q;
    ecnt_d = ecnt_q;
    base_d = base_q;
    bus_d = bus_q;
    case (st_q)
      PLLCG_SEL_RUN: begin
        if (sel_edge) begin
          base_d = ~base_q;
        end
        if (want_vco != vco_sel_q) begin
          st_d = PLLCG_SEL_DRAIN_OLD;
          ecnt_d = 2'h0;
        end
      end
      PLLCG_SEL_DRAIN_OLD: begin
        // a dead oscillator would never finish draining, so skip it
        if (vco_sel_q && !pll_en) begin
          st_d = PLLCG_SEL_FILL_NEW;
          ecnt_d = 2'h0;
        end else if (old_edge) begin
          ecnt_d = ecnt_q + 2'h1;
          if (ecnt_q == `PLLCG_SWITCH_EDGES - 2'h1) begin
            st_d = PLLCG_SEL_FILL_NEW;
            ecnt_d = 2'h0;
          end
        end
      end
      PLLCG_SEL_FILL_NEW: begin
        if (new_edge) begin
          ecnt_d = ecnt_q + 2'h1;
          if (ecnt_q == `PLLCG_SWITCH_EDGES - 2'h1) begin
            st_d = PLLCG_SEL_RUN;
            vco_sel_d = ~vco_sel_q;
            ecnt_d = 2'h0;
          end
        end
      end
      default: begin
        st_d = PLLCG_SEL_RUN;
        vco_sel_d = 1'b0;
      end
    endcase
    // losing L while on the oscillator clock forces the crystal at once
    if (vco_sel_q && linear_l == '0) begin
      st_d = PLLCG_SEL_RUN;
      vco_sel_d = 1'b0;
    end
    // bus clock: base halved, or crystal halved when monitor pin says so
    if (monitor_mode && mon_pin) begin
      if (xc_rise) begin
        bus_d = ~bus_q;
      end
    end else if (base_rise) begin
      bus_d = ~bus_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      osc_en_q <= `PLLCG_RST_BIT;
      ref_clk_q <= `PLLCG_RST_BIT;
      rcnt_q <= '0;
      rdv_q <= `PLLCG_RST_BIT;
      pcnt_q <= 8'h00;
      ncnt_q <= '0;
      vdv_q <= `PLLCG_RST_BIT;
      up_q <= `PLLCG_RST_BIT;
      dn_q <= `PLLCG_RST_BIT;
      fb_seen_q <= 2'h0;
      good_q <= 4'h0;
      acq_q <= `PLLCG_RST_BIT;
      lock_q <= `PLLCG_RST_BIT;
      irq_q <= `PLLCG_RST_BIT;
      pll_on_q <= `PLLCG_RST_BIT;
      st_q <= PLLCG_SEL_RUN;
      vco_sel_q <= `PLLCG_RST_BIT;
      ecnt_q <= 2'h0;
      base_q <= `PLLCG_RST_BIT;
      bus_q <= `PLLCG_RST_BIT;
    end else begin
      osc_en_q <= osc_en_d;
      ref_clk_q <= ref_clk_d;
      rcnt_q <= rcnt_d;
      rdv_q <= rdv_d;
      pcnt_q <= pcnt_d;
      ncnt_q <= ncnt_d;
      vdv_q <= vdv_d;
      up_q <= up_d;
      dn_q <= dn_d;
      fb_seen_q <= fb_seen_d;
      good_q <= good_d;
      acq_q <= acq_d;
      lock_q <= lock_d;
      irq_q <= irq_d;
      pll_on_q <= pll_on_d;
      st_q <= st_d;
      vco_sel_q <= vco_sel_d;
      ecnt_q <= ecnt_d;
      base_q <= base_d;
      bus_q <= bus_d;
    end
  end

  // outputs; the tracking flag follows software only in manual mode
  assign oscillator_enable = osc_en_q;
  assign pll_reference_clock = ref_clk_q;
  assign divided_reference_clock = rdv_q;
  assign vco_feedback_clock = vdv_q;
  assign base_clock_out = base_q;
  assign bus_clock_out = bus_q;
  assign pd_up = up_q;
  assign pd_down = dn_q;
  assign vco_center_mult = (L_W+3)'({3'h0, linear_l} << range_e);
  assign tracking_mode_flag = auto_bandwidth ? acq_q : tracking_mode_write;
  assign in_sync_flag = lock_q;
  assign pll_active = pll_en;
  assign vco_selected = vco_sel_q;
  assign clock_switch_busy = (st_q != PLLCG_SEL_RUN);
  assign pll_irq = irq_q;

endmodule : pllcg_control

// >>> rtl/pllcg_defines.svh
// pllcg_defines.svh: counts, nominal frequency step and reset values for the clock generator control
// assumes inclusion by bare name from the package; the control module uses its macros without including it
`ifndef PLLCG_DEFINES_SVH
`define PLLCG_DEFINES_SVH
// edges of each clock waited out when the base clock source changes
`define PLLCG_SWITCH_EDGES 2'h3
// nominal centre-of-range step of the oscillator, in hertz
`define PLLCG_F_NOM_HZ 38400
// good comparison windows needed before tracking and before in-sync
`define PLLCG_TRACK_WINDOWS 4'h2
`define PLLCG_SYNC_WINDOWS 4'h4
// reset values of control state
`define PLLCG_RST_BIT 1'b0
`endif

// >>> rtl/pllcg_pkg.sv
// pllcg_pkg.sv: types shared by the clock generator control
// assumes pllcg_defines.svh sits beside it on the include path
package pllcg_pkg;
  `include "pllcg_defines.svh"
  // base clock transition control states
  typedef enum logic [1:0] {
    PLLCG_SEL_RUN = 2'b00,
    PLLCG_SEL_DRAIN_OLD = 2'b01,
    PLLCG_SEL_FILL_NEW = 2'b10
  } pllcg_sel_state_t;
endpackage : pllcg_pkg

// >>> dv/pllcg_control_properties.sv
// pllcg_control_properties.sv: port relations of the clock generator control
// assumes a bind onto pllcg_control with one mclk domain
`timescale 1ns/10ps
module pllcg_checker #(parameter int E_W = 2, parameter int L_W = 8) (
  // clock and reset
  input wire logic mclk, reset_n,
  // controls
  input wire logic system_oscillator_enable, oscillator_stop_mode_enable, monitor_mode,
  input wire logic auto_bandwidth, tracking_mode_write, pll_irq_enable,
  input wire logic [E_W-1:0] range_e,
  input wire logic [L_W-1:0] linear_l,
  // watched outputs
  input wire logic oscillator_enable, base_clock_out, bus_clock_out, vco_feedback_clock,
  input wire logic [L_W+2:0] vco_center_mult,
  input wire logic tracking_mode_flag, in_sync_flag, pll_active, vco_selected,
  input wire logic clock_switch_busy, pll_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // generous: six slow-clock rises plus synchroniser delay
  localparam int SW_MAX = 300;
  sequence manual_settled; !auto_bandwidth [*2]; endsequence
  sequence loop_off_settled; !pll_active [*2]; endsequence
  a_osc_enable_on: assert property ((system_oscillator_enable || oscillator_stop_mode_enable) |=> oscillator_enable) else $error("oscillator not enabled");
  a_manual_quiet: assert property (manual_settled |-> !in_sync_flag && !pll_irq) else $error("lock activity in manual");
  a_manual_track: assert property (!auto_bandwidth |-> tracking_mode_flag == tracking_mode_write) else $error("manual tracking bit lost");
  a_irq_has_cause: assert property (pll_irq |-> $changed(in_sync_flag)) else $error("irq without lock change");
  a_irq_on_change: assert property ($changed(in_sync_flag) && pll_irq_enable && $past(pll_irq_enable) && auto_bandwidth && $past(auto_bandwidth) |-> pll_irq) else $error("lock change without irq");
  a_sync_needs_track: assert property (in_sync_flag |-> tracking_mode_flag) else $error("in sync while acquiring");
  a_l_zero_off: assert property (linear_l == '0 |-> !pll_active ##1 !vco_selected) else $error("loop alive with L zero");
  a_no_select_off: assert property (!pll_active |=> !vco_selected) else $error("oscillator selected while off");
  a_selected_on: assert property (vco_selected && linear_l != '0 |-> pll_active) else $error("loop off while selected");
  a_base_frozen: assert property (clock_switch_busy |=> $stable(base_clock_out)) else $error("base moved during switch");
  a_switch_bounded: assert property ($rose(clock_switch_busy) |-> ##[1:SW_MAX] !clock_switch_busy) else $error("switch never ended");
  a_bus_follows_base: assert property (!$past(monitor_mode) && $rose(base_clock_out) |-> $changed(bus_clock_out)) else $error("bus missed base rise");
  a_center_mult: assert property (vco_center_mult == ({3'h0, linear_l} << range_e)) else $error("centre multiplier wrong");
  a_feedback_idle: assert property (loop_off_settled |-> !vco_feedback_clock) else $error("feedback runs with loop off");
endmodule : pllcg_checker

// >>> dv/pllcg_clock_source.sv
// pllcg_clock_source.sv: crystal and oscillator models on the far side
// assumes half periods well above two mclk cycles, phases unrelated to mclk
`timescale 1ns/10ps
module pllcg_clock_source #(parameter int XTAL_HALF_NS = 40, parameter int VCO_HALF_NS = 20) (
  // enables from the control block
  input wire logic oscillator_enable,
  input wire logic pll_active,
  // clocks toward the control block
  output logic crystal_clock,
  output logic vco_clock
);
  // crystal swings only while enabled, parks low otherwise
  initial begin
    crystal_clock = 1'b0;
    #3;
    forever begin
      #(XTAL_HALF_NS);
      crystal_clock = oscillator_enable ? ~crystal_clock : 1'b0;
    end
  end
  // oscillator stands still while the loop is off
  initial begin
    vco_clock = 1'b0;
    #7;
    forever begin
      #(VCO_HALF_NS);
      vco_clock = pll_active ? ~vco_clock : 1'b0;
    end
  end
endmodule : pllcg_clock_source

// >>> dv/pllcg_control_tb.sv
// pllcg_control_tb.sv: directed bench for the clock generator control
// assumes crystal period 10 mclk and oscillator period 5 mclk from the model
`timescale 1ns/10ps
module pllcg_control_tb;
  logic mclk = 1'b0, reset_n = 1'b0, monitor_clock_select_pin = 1'b0, monitor_mode = 1'b0;
  logic system_oscillator_enable = 1'b1, oscillator_stop_mode_enable = 1'b0;
  logic pll_power_on = 1'b0, base_clock_source_select = 1'b0, auto_bandwidth = 1'b1;
  logic tracking_mode_write = 1'b0, pll_irq_enable = 1'b1, crystal_clock, vco_clock;
  logic [7:0] ref_div_r = 8'h01, linear_l = 8'h10;
  logic [1:0] prescale_p = 2'h0, range_e = 2'h0;
  logic [11:0] fb_div_n = 12'h002;
  logic oscillator_enable, pll_reference_clock, divided_reference_clock, vco_feedback_clock;
  logic base_clock_out, bus_clock_out, pd_up, pd_down, tracking_mode_flag, in_sync_flag;
  logic pll_active, vco_selected, clock_switch_busy, pll_irq;
  logic [10:0] vco_center_mult;
  int err_count = 0, checks = 0, irq_seen = 0, n;
  always #4 mclk = ~mclk;
  // irq is a one-cycle pulse; tally it at each falling edge, where it has settled
  always @(negedge mclk) if (pll_irq === 1'b1) irq_seen++;
  pllcg_control pllcg_control_inst (.mclk, .reset_n, .crystal_clock, .vco_clock,
    .monitor_clock_select_pin, .system_oscillator_enable, .oscillator_stop_mode_enable,
    .monitor_mode, .pll_power_on, .base_clock_source_select, .auto_bandwidth,
    .tracking_mode_write, .pll_irq_enable, .ref_div_r, .prescale_p, .fb_div_n, .range_e,
    .linear_l, .oscillator_enable, .pll_reference_clock, .divided_reference_clock,
    .vco_feedback_clock, .base_clock_out, .bus_clock_out, .pd_up, .pd_down,
    .vco_center_mult, .tracking_mode_flag, .in_sync_flag, .pll_active, .vco_selected,
    .clock_switch_busy, .pll_irq);
  pllcg_clock_source pllcg_clock_source_inst (.oscillator_enable, .pll_active,
    .crystal_clock, .vco_clock);
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  // counts are edge tallies, so one edge of slack for phase
  task automatic chk_cnt(input int got, input int exp);
    checks++;
    if (got < exp - 1 || got > exp + 1) begin
      err_count++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt
  task automatic count_rises(input int sel, input int cyc, output int cnt);
    logic prev, cur;
    cnt = 0;
    prev = 1'b1;
    repeat (cyc) begin
      @(posedge mclk);
      #1;
      case (sel)
        0: cur = base_clock_out;
        1: cur = bus_clock_out;
        2: cur = divided_reference_clock;
        default: cur = vco_feedback_clock;
      endcase
      if (cur === 1'b1 && prev === 1'b0) cnt++;
      prev = cur;
    end
    @(negedge mclk);
  endtask : count_rises
  task automatic settle(input int cyc);
    repeat (cyc) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  task automatic t_osc_center;
    for (int i = 0; i < 4; i++) begin
      {system_oscillator_enable, oscillator_stop_mode_enable} = i[1:0];
      settle(3);
      chk_val(oscillator_enable, (i != 0));
    end
    base_clock_source_select = 1'b1;
    settle(20);
    chk_val(vco_selected, 1'b0);
    base_clock_source_select = 1'b0;
    for (int e = 0; e < 4; e++) begin
      @(negedge mclk);
      range_e = e[1:0];
      linear_l = 8'hFF - 8'(e);
      #1 chk_val(vco_center_mult, 16'(linear_l) * (16'h1 << e));
    end
    @(negedge mclk);
    linear_l = 8'h10;
  endtask : t_osc_center
  task automatic t_div_mon;
    for (int r = 0; r < 3; r++) begin
      ref_div_r = 8'(r);
      count_rises(2, 400, n);
      chk_cnt(n, (r == 2) ? 20 : 40);
    end
    ref_div_r = 8'h01;
    count_rises(0, 400, n);
    chk_cnt(n, 20);
    count_rises(1, 400, n);
    chk_cnt(n, 10);
    monitor_mode = 1'b1;
    monitor_clock_select_pin = 1'b1;
    settle(4);
    count_rises(1, 400, n);
    chk_cnt(n, 20);
    monitor_mode = 1'b0;
    monitor_clock_select_pin = 1'b0;
  endtask : t_div_mon
  task automatic t_manual;
    irq_seen = 0;
    auto_bandwidth = 1'b0;
    tracking_mode_write = 1'b0;
    settle(2);
    pll_power_on = 1'b1;
    settle(100);
    tracking_mode_write = 1'b1;
    #1 chk_val(tracking_mode_flag, 1'b1);
    settle(200);
    chk_val(in_sync_flag, 1'b0);
    chk_val(irq_seen, 0);
    base_clock_source_select = 1'b1;
    settle(80);
    chk_val(vco_selected, 1'b1);
    base_clock_source_select = 1'b0;
    settle(80);
    chk_val(vco_selected, 1'b0);
    tracking_mode_write = 1'b0;
    pll_power_on = 1'b0;
    settle(4);
    auto_bandwidth = 1'b1;
    settle(4);
  endtask : t_manual
  task automatic t_lock;
    irq_seen = 0;
    pll_power_on = 1'b1;
    settle(2);
    chk_val({pll_active, tracking_mode_flag}, 2'b10);
    for (int i = 0; i < 600 && in_sync_flag !== 1'b1; i++) settle(0);
    chk_val({tracking_mode_flag, in_sync_flag}, 2'b11);
    settle(2);
    chk_val(irq_seen, 1);
    count_rises(3, 400, n);
    chk_cnt(n, 40);
  endtask : t_lock
  task automatic t_switch;
    base_clock_source_select = 1'b1;
    settle(5);
    for (int i = 0; i < 300 && clock_switch_busy === 1'b1; i++) settle(0);
    chk_val(vco_selected, 1'b1);
    count_rises(0, 400, n);
    chk_cnt(n, 40);
    chk_val(in_sync_flag, 1'b1);
    pll_power_on = 1'b0;
    settle(10);
    chk_val(pll_active, 1'b1);
    linear_l = 8'h00;
    settle(2);
    chk_val({pll_active, vco_selected}, 2'b00);
    count_rises(0, 400, n);
    chk_cnt(n, 20);
    base_clock_source_select = 1'b0;
    linear_l = 8'h10;
  endtask : t_switch
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    settle(4);
    reset_n = 1'b1;
    t_osc_center;
    t_div_mon;
    t_manual;
    t_lock;
    t_switch;
    wrap_up;
  end
  // whole run is near 4000 mclk; allow five times that
  initial begin
    #160us;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule : pllcg_control_tb
bind pllcg_control pllcg_checker #(.E_W(E_W), .L_W(L_W)) pllcg_checker_inst (.mclk,
  .reset_n, .system_oscillator_enable, .oscillator_stop_mode_enable, .monitor_mode,
  .auto_bandwidth, .tracking_mode_write, .pll_irq_enable, .range_e, .linear_l,
  .oscillator_enable, .base_clock_out, .bus_clock_out, .vco_feedback_clock,
  .vco_center_mult, .tracking_mode_flag, .in_sync_flag, .pll_active, .vco_selected,
  .clock_switch_busy, .pll_irq);
